// File: common/stack_return_rotate_exec_regs.vh
// constants for the stack, return and rotate execution slice
// assumes a 32-bit classic wishbone slave with word-aligned registers
// What this block does
// - popping into the stack pointer decrements first, then loaded byte wins.
// - byte push increments pointer, then stores operand at new location.
// - subroutine exit pops pc high then low, pointer drops by two.
// - interrupt exit frame size comes from frame mode bit in config.
// - mode clear: pop pc high, low; region ff; pointer drops two.
// - mode clear: no status word is restored, nothing else changes.
// - mode set: pop three pc bytes plus extended status, pointer drops four.
// - mode set order: pc high, pc low, pc top byte, extended status.
// - mode set restores extended status only, status word left alone.
// - either mode releases interrupt logic for the serviced level.
// - pending equal or lower request waits for one more instruction.
// - rotate left moves bit 7 to bit 0, carry kept.
// - rotate carry left: bit 7 to carry, old carry to bit 0.
// - rotate right moves bit 0 to bit 7, carry kept.
// - rotate carry right: bit 0 to carry, old carry to bit 7.
// - bit force high sets the carry or an addressable bit.
// - bit force high changes no flag unless the carry is its target.
// - register forms need escape in binary mode, none in source mode.
`ifndef STACK_RETURN_ROTATE_EXEC_REGS_VH
`define STACK_RETURN_ROTATE_EXEC_REGS_VH
// register byte offsets
`define OFF_CMD      8'h00
`define OFF_CFG      8'h04
`define OFF_SP       8'h08
`define OFF_ACC      8'h0c
`define OFF_PC       8'h10
`define OFF_STW      8'h14
`define OFF_XSTW     8'h18
`define OFF_STAT     8'h1c
`define OFF_RADDR    8'h20
`define OFF_RDATA    8'h24
`define OFF_BITS     8'h28
`define OFF_DATA     8'h2c
// command fields
`define CMD_OP_LSB   0
`define CMD_SIZE_LSB 4
`define CMD_TO_SP    6
`define CMD_REGFORM  7
`define CMD_ESC      8
`define CMD_TO_CARRY 9
`define CMD_BIT_LSB  10
// config fields
`define CFG_FRAME    0
`define CFG_SRCMODE  8
// status fields
`define ST_BUSY      0
`define ST_ESCERR    1
`define ST_HOLD      2
// carry position in status word
`define STW_CARRY    7
// operation codes
`define OP_PUSH      4'h0
`define OP_POP       4'h1
`define OP_SUB_EXIT  4'h2
`define OP_IRQ_EXIT  4'h3
`define OP_ROL       4'h4
`define OP_RCL       4'h5
`define OP_ROR       4'h6
`define OP_RCR       4'h7
`define OP_BIT_SET   4'h8
// reset values and fixed figures
`define RST_SP       8'h07
`define RST_CFG      9'h000
`define REGION_FF    8'hff
`endif

// File: rtl/stack_return_rotate_exec.v
// stack push/pop, returns, accumulator rotates and bit force high
// assumes a classic wishbone slave; stack ram lives inside this block
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "stack_return_rotate_exec_regs.vh"
module stack_return_rotate_exec (
   input  wire        mclk,        // core clock, 20 mhz
   input  wire        reset_n,     // async reset, active low
   input  wire        wb_cyc_i,    // bus cycle
   input  wire        wb_stb_i,    // bus strobe
   input  wire        wb_we_i,     // write enable
   input  wire [7:0]  wb_adr_i,    // byte address
   input  wire [3:0]  wb_sel_i,    // byte lanes
   input  wire [31:0] wb_dat_i,    // write data
   output reg  [31:0] wb_dat_o,    // read data
   output reg         wb_ack_o,    // acknowledge
   output reg         irq_release, // one-cycle release of irq logic
   output reg         service_hold // hold pending irq for one op
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   reg        state_r;
   reg [7:0]  sp_r;
   reg [23:0] pc_r;
   reg [7:0]  acc_r;
   reg [7:0]  stw_r;
   reg [7:0]  xstw_r;
   reg [8:0]  cfg_r;
   reg [31:0] bits_r;
   reg [31:0] data_r;
   reg [7:0]  raddr_r;
   reg        escerr_r;
   reg [15:0] cmd_r;
   reg [1:0]  step_r;
   reg [7:0]  ram [0:255];

   wire       req     = wb_cyc_i & wb_stb_i;
   wire       wr_fire = req & wb_we_i & wb_ack_o;
   wire       busy    = (state_r == ST_RUN);
   wire [3:0] op      = cmd_r[`CMD_OP_LSB +: 4];
   wire [1:0] size_c  = cmd_r[`CMD_SIZE_LSB +: 2];
   wire       frame4  = cfg_r[`CFG_FRAME];

   // byte-lane merge for register writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0]  sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge[i*8 +: 8] = dat[i*8 +: 8];
            end
         end
      end
   endfunction

   // last step index of the running operation
   reg [1:0] last_step;
   always @* begin
      last_step = 2'd0;
      case (op)
         `OP_PUSH, `OP_POP: begin
            if (size_c == 2'd1) begin
               last_step = 2'd1;
            end else if (size_c == 2'd2) begin
               last_step = 2'd3;
            end
         end
         `OP_SUB_EXIT: last_step = 2'd1;
         `OP_IRQ_EXIT: last_step = frame4 ? 2'd3 : 2'd1;
         default:  last_step = 2'd0;
      endcase
   end

   // escape prefix check on a command being written
   wire [15:0] cmd_new  = wb_dat_i[15:0];
   wire        esc_bad  = cmd_new[`CMD_REGFORM] &
                          (cmd_new[`CMD_ESC] == cfg_r[`CFG_SRCMODE]);
   wire        cmd_wr   = wr_fire & (wb_adr_i == `OFF_CMD) & wb_sel_i[0];
   wire        cmd_go   = cmd_wr & ~busy & ~esc_bad;
   wire        cmd_rej  = cmd_wr & ~busy & esc_bad;
   wire        run_end  = busy & (step_r == last_step);
   wire        sw_ok    = wr_fire & ~busy;

   // byte read at the current stack pointer
   wire [7:0]  top_byte = ram[sp_r];
   wire [7:0]  sp_inc   = sp_r + 8'h01;
   wire [7:0]  sp_dec   = sp_r - 8'h01;
   // push sends the most significant byte of the value first
   wire [1:0]  push_idx = last_step - step_r;
   wire [7:0]  push_byte = data_r[{push_idx, 3'b000} +: 8];
   wire        carry    = stw_r[`STW_CARRY];

   // bus handshake and registered read data
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o & ~wb_we_i) begin
            if (wb_adr_i == `OFF_CMD) begin
               wb_dat_o <= {16'h0000, cmd_r};
            end else if (wb_adr_i == `OFF_CFG) begin
               wb_dat_o <= {23'h000000, cfg_r};
            end else if (wb_adr_i == `OFF_SP) begin
               wb_dat_o <= {24'h000000, sp_r};
            end else if (wb_adr_i == `OFF_ACC) begin
               wb_dat_o <= {24'h000000, acc_r};
            end else if (wb_adr_i == `OFF_PC) begin
               wb_dat_o <= {8'h00, pc_r};
            end else if (wb_adr_i == `OFF_STW) begin
               wb_dat_o <= {24'h000000, stw_r};
            end else if (wb_adr_i == `OFF_XSTW) begin
               wb_dat_o <= {24'h000000, xstw_r};
            end else if (wb_adr_i == `OFF_STAT) begin
               wb_dat_o <= {29'h00000000, service_hold, escerr_r, busy};
            end else if (wb_adr_i == `OFF_RADDR) begin
               wb_dat_o <= {24'h000000, raddr_r};
            end else if (wb_adr_i == `OFF_RDATA) begin
               wb_dat_o <= {24'h000000, ram[raddr_r]};
            end else if (wb_adr_i == `OFF_BITS) begin
               wb_dat_o <= bits_r;
            end else if (wb_adr_i == `OFF_DATA) begin
               wb_dat_o <= data_r;
            end else begin
               wb_dat_o <= 32'h00000000;
            end
         end
      end
   end

   // stack ram: sequencer writes while busy, software only when idle
   always @(posedge mclk) begin
      if (busy & (op == `OP_PUSH)) begin
         ram[sp_inc] <= push_byte;
      end else if (sw_ok & (wb_adr_i == `OFF_RDATA) & wb_sel_i[0]) begin
         ram[raddr_r] <= wb_dat_i[7:0];
      end
   end

   // sequencer state and step count
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         step_r  <= 2'd0;
         cmd_r   <= 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               step_r <= 2'd0;
               if (cmd_go) begin
                  cmd_r   <= cmd_new;
                  state_r <= ST_RUN;
               end
            end
            default: begin
               if (run_end) begin
                  state_r <= ST_IDLE;
               end else begin
                  step_r <= step_r + 2'd1;
               end
            end
         endcase
      end
   end

   // stack pointer and data register
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sp_r   <= `RST_SP;
         data_r <= 32'h00000000;
      end else if (busy) begin
         case (op)
            `OP_PUSH: sp_r <= sp_inc;
            `OP_POP: begin
               if (cmd_r[`CMD_TO_SP]) begin
                  sp_r <= top_byte;
               end else begin
                  sp_r <= sp_dec;
                  data_r[{step_r, 3'b000} +: 8] <= top_byte;
               end
            end
            `OP_SUB_EXIT, `OP_IRQ_EXIT: sp_r <= sp_dec;
            default: sp_r <= sp_r;
         endcase
      end else if (sw_ok & (wb_adr_i == `OFF_SP) & wb_sel_i[0]) begin
         sp_r <= wb_dat_i[7:0];
      end else if (sw_ok & (wb_adr_i == `OFF_DATA)) begin
         data_r <= merge(data_r, wb_dat_i, wb_sel_i);
      end
   end

   // program counter and extended status from the return frames
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pc_r   <= 24'h000000;
         xstw_r <= 8'h00;
      end else if (busy & ((op == `OP_SUB_EXIT) |
                           (op == `OP_IRQ_EXIT))) begin
         case (step_r)
            2'd0: pc_r[15:8] <= top_byte;
            2'd1: begin
               pc_r[7:0] <= top_byte;
               if ((op == `OP_IRQ_EXIT) & ~frame4) begin
                  pc_r[23:16] <= `REGION_FF;
               end
            end
            2'd2: pc_r[23:16] <= top_byte;
            default: xstw_r <= top_byte;
         endcase
      end else if (sw_ok & (wb_adr_i == `OFF_XSTW) & wb_sel_i[0]) begin
         xstw_r <= wb_dat_i[7:0];
      end
   end

   // accumulator, status word and bit space
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         acc_r  <= 8'h00;
         stw_r  <= 8'h00;
         bits_r <= 32'h00000000;
      end else if (busy) begin
         case (op)
            `OP_ROL: acc_r <= {acc_r[6:0], acc_r[7]};
            `OP_RCL: begin
               acc_r             <= {acc_r[6:0], carry};
               stw_r[`STW_CARRY] <= acc_r[7];
            end
            `OP_ROR: acc_r <= {acc_r[0], acc_r[7:1]};
            `OP_RCR: begin
               acc_r             <= {carry, acc_r[7:1]};
               stw_r[`STW_CARRY] <= acc_r[0];
            end
            `OP_BIT_SET: begin
               if (cmd_r[`CMD_TO_CARRY]) begin
                  stw_r[`STW_CARRY] <= 1'b1;
               end else begin
                  bits_r[cmd_r[`CMD_BIT_LSB +: 5]] <= 1'b1;
               end
            end
            default: acc_r <= acc_r;
         endcase
      end else if (sw_ok & wb_sel_i[0]) begin
         if (wb_adr_i == `OFF_ACC) begin
            acc_r <= wb_dat_i[7:0];
         end else if (wb_adr_i == `OFF_STW) begin
            stw_r <= wb_dat_i[7:0];
         end else if (wb_adr_i == `OFF_BITS) begin
            bits_r <= merge(bits_r, wb_dat_i, wb_sel_i);
         end
      end else if (sw_ok & (wb_adr_i == `OFF_BITS)) begin
         bits_r <= merge(bits_r, wb_dat_i, wb_sel_i);
      end
   end

   // configuration and ram window address
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r   <= `RST_CFG;
         raddr_r <= 8'h00;
      end else if (sw_ok) begin
         if (wb_adr_i == `OFF_CFG) begin
            if (wb_sel_i[0]) begin
               cfg_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               cfg_r[8] <= wb_dat_i[`CFG_SRCMODE];
            end
         end else if ((wb_adr_i == `OFF_RADDR) & wb_sel_i[0]) begin
            raddr_r <= wb_dat_i[7:0];
         end
      end
   end

   // escape error flag: a new refusal wins over a clear
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         escerr_r <= 1'b0;
      end else if (cmd_rej) begin
         escerr_r <= 1'b1;
      end else if (wr_fire & (wb_adr_i == `OFF_STAT) & wb_sel_i[0] &
                   wb_dat_i[`ST_ESCERR]) begin
         escerr_r <= 1'b0;
      end
   end

   // interrupt release pulse and one-instruction hold
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_release  <= 1'b0;
         service_hold <= 1'b0;
      end else begin
         irq_release <= run_end & (op == `OP_IRQ_EXIT);
         if (run_end & (op == `OP_IRQ_EXIT)) begin
            service_hold <= 1'b1;
         end else if (run_end) begin
            service_hold <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/irq_ctl_model.sv
// model of the interrupt logic fed by the release pulse
// assumes the block's clock; counts each release it is handed
`timescale 1ns/1ps
`default_nettype none
module irq_ctl_model (
   input  wire logic mclk,        // core clock
   input  wire logic reset_n,     // async reset, active low
   input  wire logic irq_release, // release pulse from the block
   output var  int   releases     // releases seen since reset
);
   // count release pulses, one per irq exit
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) releases <= 0;
      else if (irq_release === 1'b1) releases <= releases + 1;
   end
endmodule
`default_nettype wire

// File: tb/srre_props.sv
// port-level checks for the stack, return and rotate slice
// assumes the bench waits for idle before each command write
`timescale 1ns/1ps
`default_nettype none
`include "stack_return_rotate_exec_regs.vh"
module srre_props (
   input wire logic        mclk,         // core clock
   input wire logic        reset_n,      // async reset
   input wire logic        wb_cyc_i,     // bus cycle
   input wire logic        wb_stb_i,     // bus strobe
   input wire logic        wb_we_i,      // write enable
   input wire logic [7:0]  wb_adr_i,     // byte address
   input wire logic [3:0]  wb_sel_i,     // byte lanes
   input wire logic [31:0] wb_dat_i,     // write data
   input wire logic [31:0] wb_dat_o,     // read data
   input wire logic        wb_ack_o,     // acknowledge
   input wire logic        irq_release,  // release pulse
   input wire logic        service_hold  // pending irq hold
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // command write accepted at this edge
   wire cmd_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o &
                 (wb_adr_i == `OFF_CMD) & wb_sel_i[0];
   ack_latency_a: assert property (
      $rose(wb_stb_i) |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   unmapped_zero_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i > `OFF_DATA |-> wb_dat_o == 0)
      else $error("unmapped read not zero");
   release_pulse_a: assert property (
      irq_release |=> !irq_release) else $error("release too long");
   release_hold_a: assert property (
      irq_release |-> service_hold) else $error("hold missing");
   hold_rise_a: assert property (
      $rose(service_hold) |-> irq_release) else $error("stray hold");
   irqexit_release_a: assert property (
      cmd_wr && wb_dat_i[3:0] == `OP_IRQ_EXIT && !wb_dat_i[7]
      |-> ##[1:8] irq_release) else $error("no release");
   subexit_quiet_a: assert property (
      cmd_wr && wb_dat_i[3:0] == `OP_SUB_EXIT |-> ##1 (!irq_release)[*6])
      else $error("release on sub exit");
endmodule
bind stack_return_rotate_exec srre_props u_props (.mclk(mclk),
   .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .irq_release(irq_release), .service_hold(service_hold));
`default_nettype wire

// File: tb/stack_return_rotate_exec_tb.sv
// self-checking bench for the stack, return and rotate slice
// assumes one-cycle wishbone ack and the offsets of the shared header
`timescale 1ns/1ps
`default_nettype none
`include "stack_return_rotate_exec_regs.vh"
module stack_return_rotate_exec_tb;
   logic        mclk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] dat = 32'h0, q;
   wire  [31:0] dat_o;
   wire         ack, rel, hold;
   int          releases, r0, err_total = 0, num_checks = 0;
   logic [7:0]  e;
   logic        ec;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value at %0t: %h not %h", $time, a, b); end end
   always #25 mclk = ~mclk;
   stack_return_rotate_exec dut (.mclk(mclk), .reset_n(reset_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .irq_release(rel), .service_hold(hold));
   irq_ctl_model partner (.mclk(mclk), .reset_n(reset_n),
      .irq_release(rel), .releases(releases));
   // one classic cycle, held until ack is sampled
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         @(posedge mclk);
         cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
         n = 0;
         do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 50);
         q = dat_o;
         if (n >= 50) begin
            err_total++;
            $display("wrong value at %0t: no ack", $time);
         end
         cyc <= 0; stb <= 0; we <= 0;
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] x);
      begin xfer(0, a, 32'h0); `CHK(q, x) end
   endtask
   // command, then poll busy with a bound
   task op(input logic [31:0] c);
      int n;
      begin
         xfer(1, `OFF_CMD, c);
         n = 0;
         do begin xfer(0, `OFF_STAT, 32'h0); n++; end
         while (q[`ST_BUSY] !== 1'b0 && n < 20);
         `CHK(q[`ST_BUSY], 1'b0)
      end
   endtask
   task t_reset;
      begin rdc(`OFF_SP, 32'h07); rdc(`OFF_CFG, 32'h0); rdc(8'h30, 32'h0); end
   endtask
   task t_push_pop;
      begin
         xfer(1, `OFF_SP, 32'h30); xfer(1, `OFF_DATA, 32'ha5);
         op(`OP_PUSH); rdc(`OFF_SP, 32'h31);
         xfer(1, `OFF_RADDR, 32'h31); rdc(`OFF_RDATA, 32'ha5);
         op(32'h40 | `OP_POP); rdc(`OFF_SP, 32'ha5);
         // word round trip, then a byte pop of a hand-written cell
         xfer(1, `OFF_SP, 32'h40); xfer(1, `OFF_DATA, 32'hbeef);
         op(32'h10 | `OP_PUSH); xfer(1, `OFF_DATA, 32'h0);
         op(32'h10 | `OP_POP); rdc(`OFF_DATA, 32'hbeef);
         rdc(`OFF_SP, 32'h40); xfer(1, `OFF_RADDR, 32'h41);
         xfer(1, `OFF_RDATA, 32'h3c); xfer(1, `OFF_SP, 32'h41);
         op(`OP_POP); rdc(`OFF_DATA, 32'hbe3c);
      end
   endtask
   // return address 0123 stacked high byte on top at 0b, then an exit
   task push_word(input logic [3:0] o);
      begin
         xfer(1, `OFF_SP, 32'h09); xfer(1, `OFF_DATA, 32'h2301);
         op(32'h10 | `OP_PUSH); op(o); rdc(`OFF_SP, 32'h09);
      end
   endtask
   task t_exits;
      begin
         push_word(`OP_SUB_EXIT); rdc(`OFF_PC, 32'h000123);
         xfer(1, `OFF_STW, 32'h55); xfer(1, `OFF_XSTW, 32'h66);
         r0 = releases; push_word(`OP_IRQ_EXIT);
         rdc(`OFF_PC, 32'hff0123);
         rdc(`OFF_STW, 32'h55); rdc(`OFF_XSTW, 32'h66);
         `CHK(releases, r0 + 1)
         `CHK(hold, 1'b1)
         op(`OP_ROL); `CHK(hold, 1'b0)
         xfer(1, `OFF_CFG, 32'h1); xfer(1, `OFF_SP, 32'h10);
         xfer(1, `OFF_DATA, 32'h77452301); op(32'h20 | `OP_PUSH);
         op(`OP_IRQ_EXIT); rdc(`OFF_PC, 32'h450123);
         rdc(`OFF_SP, 32'h10); rdc(`OFF_XSTW, 32'h77);
         rdc(`OFF_STW, 32'h55); `CHK(releases, r0 + 2)
      end
   endtask
   task t_rot;
      begin
         for (int o = 4; o < 8; o++) for (int c = 0; c < 2; c++) begin
            xfer(1, `OFF_STW, {24'h0, c[0], 7'h0}); xfer(1, `OFF_ACC, 32'hc5);
            op(o); e = 8'hc5; ec = c[0];
            case (o)
               4: e = {e[6:0], e[7]};
               5: begin e = {e[6:0], ec}; ec = 1'b1; end
               6: e = {e[0], e[7:1]};
               default: begin e = {ec, e[7:1]}; ec = 1'b1; end
            endcase
            rdc(`OFF_ACC, {24'h0, e});
            rdc(`OFF_STW, {24'h0, ec, 7'h0});
         end
      end
   endtask
   task t_bit_force_high_op;
      begin
         xfer(1, `OFF_STW, 32'h0); op(32'h200 | `OP_BIT_SET);
         rdc(`OFF_STW, 32'h80);
         xfer(1, `OFF_STW, 32'h0); xfer(1, `OFF_BITS, 32'h0);
         op(32'h1400 | `OP_BIT_SET);
         rdc(`OFF_BITS, 32'h20); rdc(`OFF_STW, 32'h0);
      end
   endtask
   task t_esc;
      begin
         xfer(1, `OFF_CFG, 32'h0); xfer(1, `OFF_SP, 32'h20);
         op(32'h80 | `OP_PUSH); rdc(`OFF_STAT, 32'h2);
         rdc(`OFF_SP, 32'h20); xfer(1, `OFF_STAT, 32'h2);
         op(32'h180 | `OP_PUSH); rdc(`OFF_SP, 32'h21);
         xfer(1, `OFF_CFG, 32'h100); op(32'h80 | `OP_PUSH);
         rdc(`OFF_SP, 32'h22); rdc(`OFF_STAT, 32'h0);
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // main sequence after two reset cycles
   initial begin
      repeat (2) @(posedge mclk);
      reset_n <= 1;
      t_reset; t_push_pop; t_exits; t_rot; t_bit_force_high_op; t_esc;
      print_verdict;
   end
   // watchdog far beyond the expected run
   initial begin
      #2000000;
      err_total++;
      print_verdict;
   end
endmodule
`default_nettype wire
